// file: rtl/ocf_pkg.sv
// offset cancellation package: register map, field layout, startup schedule and coefficients
// assumes a 250 MHz system clock and 256 us estimator sample period
package ocf_pkg;
  localparam int CLK_MHZ    = 250;
  localparam int SAMPLE_US  = 256;
  localparam int SAMPLE_CYC = SAMPLE_US * CLK_MHZ;
  localparam int SLOW_DIV   = 4;      // final narrow option runs at 1024 us
  localparam int HOLD_US    = 15000;  // freeze extension after self-test
  localparam int COEF_W     = 24;
  localparam int TICK_W     = 13;
  localparam real COEF_ONE  = 16777216.0;
  // phase start times in us for phases 1..5 and the final phase
  localparam int START_US [6] = '{4096, 8192, 24580, 90110, 352300, 1401000};

  // least times round up to whole sample ticks
  function automatic logic [TICK_W-1:0] us_to_ticks(input int us);
    us_to_ticks = TICK_W'((us + SAMPLE_US - 1) / SAMPLE_US);
  endfunction
  localparam logic [TICK_W-1:0] HOLD_TICKS = us_to_ticks(HOLD_US);

  function automatic logic [COEF_W-1:0] q24(input real r);
    q24 = COEF_W'($rtoi(r * COEF_ONE + 0.5));
  endfunction
  // index 0..5 startup phases, 6 final 0.04 Hz, 7 final 0.005 Hz
  localparam logic [COEF_W-1:0] GAIN_TAB [8] = '{
    q24(0.234051465988159), q24(0.063805103302002), q24(0.0163367986679077),
    q24(0.00410926342010498), q24(0.00102889537811279), q24(0.000257253646850586),
    q24(0.0000643377478321934), q24(0.00003216939131789331)};
  localparam logic [COEF_W-1:0] NUM_TAB [8] = '{
    q24(0.49999988079071), q24(0.49999988079071), q24(0.49999988079071),
    q24(0.49999988079071), q24(0.49999988079071), q24(0.49999988079071),
    q24(0.49999988079071), q24(0.5)};
  // negated feedback tap, stored as a positive fraction
  localparam logic [COEF_W-1:0] DEN_TAB [8] = '{
    q24(0.765948414802551), q24(0.936194777488708), q24(0.983663082122802),
    q24(0.995890617370605), q24(0.998970985412597), q24(0.999742627143859),
    q24(0.9999356623), q24(0.99996783025562763214)};

  // register byte offsets
  localparam logic [7:0] CFG_OFS  = 8'h00;
  localparam logic [7:0] RATE_OFS = 8'h04;
  localparam logic [7:0] STAT_OFS = 8'h08;
  localparam logic [7:0] EST_OFS  = 8'h0C;
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  localparam logic [15:0] STEP_RST = 16'h0001;
  localparam logic [15:0] RLI_RST  = 16'h0001;
  localparam logic [1:0] SEL_RL   = 2'h1;  // 0.04 Hz with rate limiting

  // channel_config_word_four layout, bits 7..0
  typedef struct packed {
    logic       psi5;
    logic [3:0] self_test_control;
    logic [1:0] offset_filter_select;
    logic       enable;
  } cfg_s;
  localparam cfg_s CFG_RST = '0;

  typedef enum logic [6:0] {
    PH0 = 7'h01, PH1 = 7'h02, PH2 = 7'h04, PH3 = 7'h08,
    PH4 = 7'h10, PH5 = 7'h20, PHF = 7'h40
  } phase_e;
endpackage

// file: rtl/offset_cancel_filter.sv
// offset cancellation filter with timed startup phases and an AXI4-Lite register slave
// assumes in_valid/in_data are synchronous to aclk; init_done pulses at the end of init phase 3
//
// Implementation choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - offset removal can be switched on or off by software
// - first-order estimator, 24-bit coefficients, equal taps, updated every 256 us
// - startup phases advance at fixed times after reset
// - each phase has its own coefficients; final slow option uses 1024 us
// - rate limiting is bypassed in every startup phase
// - in normal mode the select field picks corner and rate limiting
// - rate limiting only with the 0.04 Hz setting, never with 0.005 Hz
// - with rate limiting the output moves at most one step per interval
// - self-test codes 8 to F freeze the offset output
// - freeze lasts a further 15 ms after self-test ends
// - PSI5 skips phase 5; final phase starts at the later of init phase 3 end and phase 4 start
module offset_cancel_filter
  import ocf_pkg::*;
#(
  parameter int DW            = 16,
  parameter int SAMPLE_CYCLES = SAMPLE_CYC
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic [7:0]    awaddr,
  input  wire logic          awvalid,
  output logic               awready,
  input  wire logic [31:0]   wdata,
  input  wire logic [3:0]    wstrb,
  input  wire logic          wvalid,
  output logic               wready,
  output logic [1:0]         bresp,
  output logic               bvalid,
  input  wire logic          bready,
  input  wire logic [7:0]    araddr,
  input  wire logic          arvalid,
  output logic               arready,
  output logic [31:0]        rdata,
  output logic [1:0]         rresp,
  output logic               rvalid,
  input  wire logic          rready,
  input  wire logic          init_done,
  input  wire logic          in_valid,
  input  wire logic [DW-1:0] in_data,
  output logic               out_valid,
  output logic [DW-1:0]      out_data
);
  localparam int DIV_W = $clog2(SAMPLE_CYCLES);
  localparam int YW    = DW + COEF_W;

  // status and data fields are 16 bits wide
  if (DW < 8 || DW > 16 || SAMPLE_CYCLES < 3) begin : g_bad_param
    $error("offset_cancel_filter: unsupported parameter values");
  end

  cfg_s                     cfg_ff;
  logic [15:0]              step_ff, rli_ff, rl_cnt_ff;
  logic [DIV_W-1:0]         div_ff;
  logic [TICK_W-1:0]        tcnt_ff, hold_ff;
  logic [1:0]               slow_ff;
  phase_e                   phase_ff, nxt_phase;
  logic                     init_seen_ff;
  logic signed [YW-1:0]     y_ff;
  logic signed [DW-1:0]     x_ff, x1_ff, off_ff;
  logic                     tick, fin, st_act, frozen, rl_act, upd;
  logic [2:0]               coef_idx;
  logic signed [DW-1:0]     est;
  logic                     aw_ff, w_ff;
  logic [7:0]               awaddr_ff;
  logic [31:0]              wdata_ff;
  logic [3:0]               wstrb_ff;

  function automatic logic [2:0] ph_idx(input phase_e p);
    ph_idx = 3'h0;
    for (int i = 0; i < 7; i++) begin
      if (p[i]) ph_idx = 3'(i);
    end
  endfunction

  // one filter step: y = -d1*y + a0*n0*(x + x1)
  function automatic logic signed [YW-1:0] lpf_step(input logic signed [YW-1:0] y,
      input logic signed [DW-1:0] x, input logic signed [DW-1:0] x1, input logic [2:0] i);
    logic [2*COEF_W-1:0]        g;
    logic signed [YW+COEF_W:0]  fb;
    logic signed [DW+COEF_W+1:0] ff;
    g  = GAIN_TAB[i] * NUM_TAB[i];
    fb = $signed({1'b0, DEN_TAB[i]}) * y;
    ff = $signed({1'b0, g[2*COEF_W-1:COEF_W]}) * ($signed({x[DW-1], x}) + x1);
    lpf_step = fb[YW+COEF_W-1:COEF_W] + ff[YW-1:0];
  endfunction

  // move toward target by at most step, landing on it when close
  function automatic logic signed [DW-1:0] step_toward(input logic signed [DW-1:0] cur,
      input logic signed [DW-1:0] tgt, input logic [15:0] step);
    logic signed [DW+1:0] d, s;
    d = (DW+2)'(tgt) - (DW+2)'(cur);
    s = $signed({2'b00, step[DW-1:0]});
    if (d > s) step_toward = DW'(cur + step[DW-1:0]);
    else if (d < -s) step_toward = DW'(cur - step[DW-1:0]);
    else step_toward = tgt;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
      input logic [3:0] be);
    for (int b = 0; b < 4; b++) begin
      merge[8*b +: 8] = be[b] ? nw[8*b +: 8] : old[8*b +: 8];
    end
  endfunction

  assign tick = (div_ff == DIV_W'(SAMPLE_CYCLES - 1));

  // sample period divider
  always_ff @(posedge aclk) begin
    if (!aresetn) div_ff <= '0;
    else div_ff <= tick ? '0 : div_ff + DIV_W'(1);
  end

  // time since reset in ticks, saturating at the last phase start
  always_ff @(posedge aclk) begin
    if (!aresetn) tcnt_ff <= '0;
    else if (tick && tcnt_ff != us_to_ticks(START_US[5])) tcnt_ff <= tcnt_ff + TICK_W'(1);
  end

  // sticky record of init phase 3 end
  always_ff @(posedge aclk) begin
    if (!aresetn) init_seen_ff <= 1'b0;
    else if (init_done) init_seen_ff <= 1'b1;
  end

  always_comb begin
    nxt_phase = phase_ff;
    unique case (phase_ff)
      PH0: if (tcnt_ff >= us_to_ticks(START_US[0])) nxt_phase = PH1;
      PH1: if (tcnt_ff >= us_to_ticks(START_US[1])) nxt_phase = PH2;
      PH2: if (tcnt_ff >= us_to_ticks(START_US[2])) nxt_phase = PH3;
      PH3: if (tcnt_ff >= us_to_ticks(START_US[3])) nxt_phase = PH4;
      PH4: begin
        if (cfg_ff.psi5) begin
          if (init_seen_ff) nxt_phase = PHF;
        end else if (tcnt_ff >= us_to_ticks(START_US[4])) nxt_phase = PH5;
      end
      PH5: if (tcnt_ff >= us_to_ticks(START_US[5])) nxt_phase = PHF;
      PHF: nxt_phase = PHF;
      default: nxt_phase = PH0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) phase_ff <= PH0;
    else phase_ff <= nxt_phase;
  end

  // coefficient set per phase; final option from select field
  assign fin      = (phase_ff == PHF);
  assign coef_idx = ph_idx(phase_ff) | {2'b00, fin & cfg_ff.offset_filter_select[1]};
  // bypass in startup; only the 0.04 Hz option may limit
  assign rl_act   = fin && (cfg_ff.offset_filter_select == SEL_RL);
  assign st_act   = cfg_ff.self_test_control[3];
  assign frozen   = st_act || (hold_ff != '0);
  // slow option updates every fourth tick
  assign upd      = tick && !frozen && (coef_idx != 3'h7 || slow_ff == 2'(SLOW_DIV - 1));
  assign est      = y_ff[YW-1:COEF_W];

  always_ff @(posedge aclk) begin
    if (!aresetn) slow_ff <= '0;
    else if (tick) slow_ff <= slow_ff + 2'h1;
  end

  // freeze extension, reloaded for as long as self-test is on
  always_ff @(posedge aclk) begin
    if (!aresetn) hold_ff <= '0;
    else if (st_act) hold_ff <= HOLD_TICKS;
    else if (tick && hold_ff != '0) hold_ff <= hold_ff - TICK_W'(1);
  end

  // latest input sample feeds the estimator
  always_ff @(posedge aclk) begin
    if (!aresetn) x_ff <= '0;
    else if (in_valid) x_ff <= in_data;
  end

  // estimator update; held while frozen so self-test stimulus stays out
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      y_ff  <= '0;
      x1_ff <= '0;
    end else if (upd) begin
      y_ff  <= lpf_step(y_ff, x_ff, x1_ff, coef_idx);
      x1_ff <= x_ff;
    end
  end

  // rate limit interval counter in ticks; zero acts as one
  always_ff @(posedge aclk) begin
    if (!aresetn || !rl_act) rl_cnt_ff <= '0;
    else if (tick && !frozen) rl_cnt_ff <= (rl_cnt_ff + 16'h1 >= rli_ff) ? '0 : rl_cnt_ff + 16'h1;
  end

  // offset output; no change while frozen
  always_ff @(posedge aclk) begin
    if (!aresetn) off_ff <= '0;
    else if (!frozen) begin
      if (rl_act) begin
        if (tick && rl_cnt_ff + 16'h1 >= rli_ff) off_ff <= step_toward(off_ff, est, step_ff);
      end else off_ff <= est;
    end
  end

  // subtract offset; pass through when disabled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end else begin
      out_valid <= in_valid;
      if (in_valid) out_data <= cfg_ff.enable ? DW'(in_data - off_ff) : in_data;
    end
  end

  // write channel capture; address and data may come in either order
  assign awready = !aw_ff && !bvalid;
  assign wready  = !w_ff && !bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ff     <= 1'b0;
      w_ff      <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff  <= '0;
      wstrb_ff  <= '0;
    end else if (aw_ff && w_ff) begin
      aw_ff <= 1'b0;
      w_ff  <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        aw_ff     <= 1'b1;
        awaddr_ff <= awaddr;
      end
      if (wvalid && wready) begin
        w_ff     <= 1'b1;
        wdata_ff <= wdata;
        wstrb_ff <= wstrb;
      end
    end
  end

  // register writes and write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_ff  <= CFG_RST;
      step_ff <= STEP_RST;
      rli_ff  <= RLI_RST;
      bvalid  <= 1'b0;
      bresp   <= RESP_OK;
    end else if (aw_ff && w_ff) begin
      bvalid <= 1'b1;
      bresp  <= RESP_OK;
      unique case ({awaddr_ff[7:2], 2'b00})
        CFG_OFS:  cfg_ff <= cfg_s'(8'(merge(32'(cfg_ff), wdata_ff, wstrb_ff)));
        RATE_OFS: {rli_ff, step_ff} <= merge({rli_ff, step_ff}, wdata_ff, wstrb_ff);
        STAT_OFS, EST_OFS: bresp <= RESP_OK;  // read-only, write ignored
        default:  bresp <= RESP_ERR;
      endcase
    end else if (bready) bvalid <= 1'b0;
  end

  // read channel, one read in flight
  assign arready = !rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= '0;
      rresp  <= RESP_OK;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp  <= RESP_OK;
      unique case ({araddr[7:2], 2'b00})
        CFG_OFS:  rdata <= 32'(cfg_ff);
        RATE_OFS: rdata <= {rli_ff, step_ff};
        STAT_OFS: rdata <= {16'(off_ff), 7'h00, rl_act, frozen, 7'(phase_ff)};
        EST_OFS:  rdata <= 32'(est);
        default: begin
          rdata <= '0;
          rresp <= RESP_ERR;
        end
      endcase
    end else if (rready) rvalid <= 1'b0;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  div_period_a: assert property (tick |=> !tick [*2])
    else $error("sample tick too frequent");
  upd_on_tick_a: assert property (!tick |=> $stable(y_ff))
    else $error("estimator updated off tick");
  phase_one_a: assert property ((phase_ff == PH0 && tcnt_ff >= 13'd16) |=> phase_ff == PH1)
    else $error("phase 1 not entered on time");
  slow_pick_a: assert property ((coef_idx == 3'h7 && slow_ff != 2'h3) |=> $stable(y_ff))
    else $error("slow option updated too often");
  startup_bypass_a: assert property ((!fin && !frozen) |=> off_ff == $past(est))
    else $error("rate limit during startup");
  rl_select_a: assert property ((!frozen && coef_idx == 3'h7) |=> off_ff == $past(est))
    else $error("rate limit with slow option");
  rl_step_a: assert property ((rl_act && $past(rl_act) && $past(off_ff) < est) |->
    off_ff - $past(off_ff) <= $signed({1'b0, step_ff}))
    else $error("offset moved more than one step");
  st_freeze_a: assert property ((st_act && $past(st_act)) |-> $stable(off_ff))
    else $error("offset changed during self-test");
  hold_load_a: assert property ($fell(st_act) |-> hold_ff == HOLD_TICKS ##1 frozen)
    else $error("freeze not extended");
  psi5_final_a: assert property ((phase_ff == PH4 && cfg_ff.psi5 && init_seen_ff) |=>
    phase_ff == PHF)
    else $error("psi5 final phase not entered");
  out_sub_a: assert property ((in_valid && cfg_ff.enable) |=>
    out_valid && out_data == DW'($past(in_data) - $past(off_ff)))
    else $error("output not offset corrected");
  out_pass_a: assert property ((in_valid && !cfg_ff.enable) |=> out_data == $past(in_data))
    else $error("output altered while disabled");

  reach_final_c: cover property (phase_ff == PH5 ##1 phase_ff == PHF);
  rl_move_c: cover property (rl_act && tick && !$stable(off_ff));
  st_release_c: cover property ($fell(st_act) ##[1:5] frozen);
endmodule
`default_nettype wire

// file: test/dsp_chain_model.sv
// model of the preceding sensor dsp chain: periodic samples at a set level
// assumes level and init_req come from the bench in the aclk domain
`timescale 1ns/10ps
`default_nettype none
module dsp_chain_model (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [15:0] level,
  input  wire logic        init_req,
  output logic             in_valid,
  output logic [15:0]      in_data,
  output logic             init_done
);
  logic [1:0] div_ff;
  // one sample every fourth cycle; data toggles between samples so stale use shows
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_ff   <= 2'h0;
      in_valid <= 1'b0;
      in_data  <= 16'h0000;
    end else begin
      div_ff   <= div_ff + 2'h1;
      in_valid <= (div_ff == 2'h3);
      in_data  <= (div_ff == 2'h3) ? level : ~level;
    end
  end
  // end of init phase 3 reported as a one-cycle pulse
  always_ff @(posedge aclk) init_done <= aresetn & init_req;
endmodule
`default_nettype wire

// file: test/tb_offset_cancel_filter.sv
// testbench: axi4-lite register tasks, timed phase walk, freeze and rate limit checks
// assumes dsp_chain_model as sample source; short sample period keeps the run short
`timescale 1ns/10ps
`default_nettype none
module tb_offset_cancel_filter
  import ocf_pkg::*;
;
  localparam int SC = 8;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, init_req = 1'b0;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0]  wstrb = 4'hF;
  logic [15:0] level = 16'h0064;
  logic        awready, wready, bvalid, arready, rvalid, init_done, in_valid, out_valid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata, s, t;
  logic [15:0] in_data, out_data;
  int          n_mismatch = 0;
  int          total_checks = 0;
  int          cyc = 0;
  int          thr [6] = '{16, 32, 97, 352, 1377, 5473};

  always #2 aclk = ~aclk;
  // cycles since reset release, the time base of the phase schedule
  always @(posedge aclk) cyc <= aresetn ? cyc + 1 : 0;

  offset_cancel_filter #(.DW(16), .SAMPLE_CYCLES(SC)) dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .init_done(init_done), .in_valid(in_valid), .in_data(in_data),
    .out_valid(out_valid), .out_data(out_data));
  dsp_chain_model src (.aclk(aclk), .aresetn(aresetn), .level(level), .init_req(init_req),
    .in_valid(in_valid), .in_data(in_data), .init_done(init_done));

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic hang(input string nm);
    n_mismatch++;
    $display("MISMATCH %s exp answer seen none", nm);
    conclude();
  endtask
  // write: address and data offered together, each released when taken
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) break;
    end
    if (n == 40) hang("bvalid");
    check("bresp", bresp, er);
    bready <= 1'b0;
  endtask
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) break;
    end
    if (n == 40) hang("rvalid");
    d = rdata;
    check("rresp", rresp, er);
    rready <= 1'b0;
  endtask
  task automatic stat();
    axi_read(STAT_OFS, s, RESP_OK);
  endtask
  task automatic wait_to(input int c);
    while (cyc < c) @(posedge aclk);
  endtask
  // next output sample compared with its expected value
  task automatic chk_out(input logic [15:0] exp);
    int n;
    for (n = 0; n < 20 && out_valid !== 1'b1; n++) @(posedge aclk);
    if (n == 20) hang("out_valid");
    check("out_data", out_data, exp);
  endtask
  function automatic logic [31:0] cfgw(input logic p, input logic [3:0] st,
                                       input logic [1:0] sel, input logic en);
    cfgw = {24'h000000, p, st, sel, en};
  endfunction

  initial begin
    int i, c0;
    logic [15:0] o, d;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    axi_read(CFG_OFS, s, RESP_OK);
    check("cfg", s, 32'h00000000);
    axi_read(RATE_OFS, s, RESP_OK);
    check("rate", s, {RLI_RST, STEP_RST});
    axi_read(8'h10, s, RESP_ERR);
    axi_write(8'h10, 32'hFFFFFFFF, RESP_ERR);
    axi_write(CFG_OFS, cfgw(1'b0, 4'h0, SEL_RL, 1'b0), RESP_OK);
    chk_out(level);
    // phase walk with limiting asked for but bypassed until the final phase
    for (i = 0; i < 6; i++) begin
      wait_to(thr[i] * SC - 10);
      stat();
      check("phase", s[6:0], 7'h01 << i);
      check("limit", s[8], 1'b0);
      wait_to(thr[i] * SC + 10);
      stat();
      check("phase", s[6:0], 7'h01 << (i + 1));
    end
    check("limit", s[8], 1'b1);
    axi_read(EST_OFS, t, RESP_OK);
    check("estimate", t >= 90 && t <= 100, 1'b1);
    axi_write(CFG_OFS, cfgw(1'b0, 4'h0, 2'h2, 1'b0), RESP_OK);
    stat();
    check("limit", s[8], 1'b0);
    axi_write(CFG_OFS, cfgw(1'b0, 4'h0, SEL_RL, 1'b0), RESP_OK);
    // step 1 every 100 ticks while the estimate runs ahead
    axi_write(RATE_OFS, {16'd100, 16'd1}, RESP_OK);
    level <= 16'd1000;
    stat();
    o = s[31:16];
    c0 = cyc;
    wait_to(c0 + 1000 * SC);
    stat();
    d = s[31:16] - o;
    check("step", d >= 16'd9 && d <= 16'd11, 1'b1);
    axi_read(EST_OFS, t, RESP_OK);
    check("lead", t[15:0] - o >= 16'd30, 1'b1);
    axi_write(RATE_OFS, {16'd1, 16'd1}, RESP_OK);
    for (i = 0; i < 16; i++) begin
      axi_write(CFG_OFS, cfgw(1'b0, 4'(i), SEL_RL, 1'b1), RESP_OK);
      stat();
      if (i == 8) o = s[31:16];
      check("frozen", s[7], i >= 8);
      if (i >= 8) check("held", s[31:16], o);
    end
    chk_out(16'd1000 - o);
    axi_write(CFG_OFS, cfgw(1'b0, 4'h0, SEL_RL, 1'b1), RESP_OK);
    c0 = cyc;
    wait_to(c0 + 59 * SC - 40);
    stat();
    check("hold", {s[7], s[31:16]}, {1'b1, o});
    wait_to(c0 + 59 * SC + 80);
    stat();
    check("resume", !s[7] && s[31:16] > o, 1'b1);
    // second reset: psi5 schedule, init end arrives during phase 4
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    axi_write(CFG_OFS, cfgw(1'b1, 4'h0, 2'h0, 1'b0), RESP_OK);
    wait_to(352 * SC + 10);
    stat();
    check("psi5 phase", s[6:0], 7'h10);
    // phase five is skipped: phase four must outlast its timed end
    wait_to(1377 * SC + 10);
    stat();
    check("psi5 phase", s[6:0], 7'h10);
    init_req <= 1'b1;
    @(posedge aclk);
    init_req <= 1'b0;
    wait_to(1377 * SC + 40);
    stat();
    check("psi5 phase", s[6:0], 7'h40);
    conclude();
  end
endmodule
`default_nettype wire
